//--- rtl/cmcrp_pkg.sv
package cmcrp_pkg;

    // ========================================================
    // Register byte offsets on the Wishbone slave.
    localparam logic [11:0] REG_CTRL1 = 12'h000;
    localparam logic [11:0] REG_CFG2 = 12'h004;
    localparam logic [11:0] REG_FCTRL = 12'h008;
    localparam logic [11:0] REG_INTF = 12'h00C;
    localparam logic [11:0] REG_INTE = 12'h010;
    localparam logic [11:0] REG_BUFCON = 12'h014;
    localparam logic [11:0] REG_RXFUL = 12'h018;
    localparam logic [11:0] REG_VEC = 12'h01C;
    localparam logic [11:0] REG_BUFSEL = 12'h020;
    localparam logic [11:0] REG_BUFID = 12'h024;
    localparam logic [11:0] REG_BUFDLO = 12'h028;
    localparam logic [11:0] REG_BUFDHI = 12'h02C;
    localparam logic [11:0] REG_STAT = 12'h030;
    localparam logic [11:0] REG_MASK0 = 12'h080;
    localparam logic [3:0] FILT_PAGE = 4'h1;

    // ========================================================
    // Field positions.
    localparam int REQ_LSB = 8;
    localparam int MODE_LSB = 5;
    localparam int WAKFEN_BIT = 14;
    localparam int AREA_LSB = 13;
    localparam int FSTART_LSB = 0;
    localparam int RX_BUFFER_FLAG_BIT = 1;
    localparam int OVF_BIT = 2;
    localparam int WAKE_FLAG_BIT = 6;
    localparam int RX_BUFFER_IRQ_ENABLE_BIT = 1;
    localparam int DIR_LSB = 0;
    localparam int TX_REQUEST_BIT_LSB = 8;
    localparam int TX_ABORT_FLAG_LSB = 16;
    localparam int FEXT_BIT = 3;
    localparam int FEN_BIT = 4;
    localparam int FSID_LSB = 5;
    localparam int FPTR_LSB = 0;
    localparam int FMSEL_LSB = 4;
    localparam logic [3:0] FIFO_PTR = 4'hF;
    localparam logic [4:0] VEC_NO_FILTER = 5'h10;

    // ========================================================
    // Timing.
    localparam int CLK_NS = 5;
    localparam int IDLE_BITS = 11;
    localparam int BIT_NS = 1000;
    localparam int BIT_CYCLES = (BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_FILT_NS = 500;
    localparam int WAKE_CYCLES = (WAKE_FILT_NS + CLK_NS - 1) / CLK_NS;

    // ========================================================
    // Operating modes and the mode change sequencer.
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_DISABLE = 3'h1,
        MODE_LOOPBACK = 3'h2,
        MODE_LISTEN_ONLY = 3'h3,
        MODE_INIT = 3'h4,
        MODE_LISTEN_ALL = 3'h7
    } cmcrp_mode_t;

    typedef enum logic [1:0] {
        ST_STEADY = 2'b01,
        ST_PEND = 2'b10
    } cmcrp_seq_t;

    // Protocol engine to this block, same clock.
    typedef struct packed {
        logic msg_valid;
        logic msg_err;
        logic msg_ide;
        logic [28:0] msg_id;
        logic [63:0] msg_data;
        logic tx_busy;
        logic tx_bit;
    } cmcrp_pe_in_t;

    // This block to the protocol engine.
    typedef struct packed {
        logic rx_bit;
        logic rx_en;
        logic tx_en;
        logic tx_allow;
        logic ack_en;
        logic errflag_en;
        logic errcnt_clr;
        logic errcnt_run;
        logic ignore_err;
        logic [7:0] tx_req;
    } cmcrp_pe_out_t;

endpackage : cmcrp_pkg

//--- rtl/cmcrp_top.sv
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - Mode requested by field, shown in status
// - Mode changes wait for 11 recessive bits
// - Init mode: no traffic, clear error counters
// - Config registers writable only in init mode
// - Init entry waits for transmission end
// - Request 001 enters disable after idle bus
// - Disable: no traffic, wake flag, counters kept
// - Disable mode releases both bus pins
// - Wake low-pass filter when enable bit set
// - Disable during startup wait aborts transmit
// - Request 000 gives normal send and receive
// - Listen-only: passive, no flags, no acknowledge
// - Listen-all: ignore errors, store everything
// - Loopback joins internal transmit to receive
// - 32 buffers, first 8 direction selectable
// - Area size field, filters reach 15 buffers
// - Assemble, then store only accepted messages, except in listen-all
// - Receive flag set on reception, software clears
// - Pointer 1111 stores into next FIFO buffer
// - FIFO spans start index to area limit
// - Matching filter pointer picks target buffer
// - Frame format must equal filter extended select
// - Zero mask bit always matches
// - Receive indication right after end of frame
module cmcrp_top #(
    parameter int NFILT = 16,
    parameter int BIT_CYCLES = cmcrp_pkg::BIT_CYCLES,
    parameter int WAKE_CYCLES = cmcrp_pkg::WAKE_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire cmcrp_pkg::cmcrp_pe_in_t pe_i,
    output cmcrp_pkg::cmcrp_pe_out_t pe_o,
    input wire logic bus_receive_pin_i,
    output logic bus_transmit_pin_o,
    output logic bus_transmit_oe_o,
    output logic bus_receive_owned_o,
    output logic rx_irq_o
);

    typedef struct packed {
        cmcrp_pkg::cmcrp_seq_t seq;
        logic [2:0] mode;
        logic [2:0] req;
        logic wake_fen;
        logic [2:0] area_size;
        logic [4:0] fifo_start;
        logic rx_ie;
        logic [7:0] dir;
        logic [7:0] tx_request_bit;
        logic [7:0] tx_abort_flag;
        logic [31:0] rxful;
        logic rx_buffer_flag;
        logic ovf;
        logic wake_flag;
        logic [4:0] vec_buf;
        logic [4:0] vec_filt;
        logic [4:0] bufsel;
        logic [15:0][28:0] fid;
        logic [15:0] fext;
        logic [15:0] fen;
        logic [15:0][3:0] fptr;
        logic [15:0][1:0] fmsel;
        logic [2:0][28:0] mask;
        logic [31:0][29:0] bid;
        logic [31:0][63:0] bdata;
        logic [15:0] bitdiv;
        logic [3:0] idle_cnt;
        logic [3:0] fresh_cnt;
        logic [1:0] sync;
        logic [15:0] wake_cnt;
        logic ack;
        logic [31:0] rdat;
        cmcrp_pkg::cmcrp_pe_out_t po;
        logic tx_pin;
        logic tx_oe;
        logic rx_owned;
        logic irq;
    } cmcrp_state_t;

    cmcrp_state_t s;
    cmcrp_state_t next_s;

    // ========================================================
    // Helper functions.

    // Byte-lane merge of a write into the current register word.
    function automatic logic [31:0] merge_f(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (dat & m);
    endfunction : merge_f

    // A zero mask bit accepts either value; standard frames ignore the extended bits.
    function automatic logic match_f(input logic [28:0] fid, input logic [28:0] msk, input logic [28:0] id,
                                     input logic ide);
        logic [28:0] diff;
        diff = (fid ^ id) & msk;
        return ide ? (diff == 29'h0) : (diff[28:18] == 11'h0);
    endfunction : match_f

    // Buffer area limit, four buffers per size step, 32 at the top code.
    function automatic logic [5:0] area_limit_f(input logic [2:0] code);
        return 6'(({3'h0, code} + 6'h1) << 2);
    endfunction : area_limit_f

    // Lowest empty buffer in [lo, hi); bit 5 set means none is free.
    function automatic logic [5:0] first_free_f(input logic [31:0] full, input logic [4:0] lo, input logic [5:0] hi);
        logic [5:0] r;
        r = 6'h20;
        for (int i = 31; i >= 0; i--) begin
            if (6'(i) >= {1'b0, lo} && 6'(i) < hi && !full[i]) begin
                r = 6'(i);
            end
        end
        return r;
    endfunction : first_free_f

    function automatic logic tx_capable_f(input logic [2:0] m);
        return m == cmcrp_pkg::MODE_NORMAL || m == cmcrp_pkg::MODE_LOOPBACK;
    endfunction : tx_capable_f

    // ========================================================
    // Combinational helpers shared by the bus and receive logic.
    logic req_take;
    logic bit_en;
    logic [31:0] rd;
    logic [31:0] wv;
    logic [31:0] w1c;
    logic [3:0] fidx;
    logic [1:0] fsub;
    logic in_filt;
    logic cfg_open;
    logic hit_found;
    logic [3:0] hit;
    logic [28:0] cur_mask;
    logic use_fifo;
    logic [5:0] free_idx;
    logic [4:0] tgt;
    logic tgt_ok;
    logic store;
    logic rx_mode;
    logic [5:0] limit;

    assign req_take = wb_cyc_i && wb_stb_i && !s.ack;
    assign bit_en = s.bitdiv == 16'(BIT_CYCLES - 1);
    assign fidx = wb_adr_i[7:4];
    assign fsub = wb_adr_i[3:2];
    assign in_filt = wb_adr_i[11:8] == cmcrp_pkg::FILT_PAGE && 32'(fidx) < 32'(NFILT);
    assign cfg_open = s.mode == cmcrp_pkg::MODE_INIT;
    assign limit = area_limit_f(s.area_size);
    assign rx_mode = s.mode == cmcrp_pkg::MODE_NORMAL || s.mode == cmcrp_pkg::MODE_LISTEN_ONLY ||
                     s.mode == cmcrp_pkg::MODE_LISTEN_ALL || s.mode == cmcrp_pkg::MODE_LOOPBACK;
    assign w1c = wb_dat_i & {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wv = merge_f(rd, wb_dat_i, wb_sel_i);

    // Register read mux; unmapped addresses read as zero.
    always_comb begin
        rd = 32'h0;
        if (in_filt) begin
            case (fsub)
                2'h0: rd = {16'h0, s.fid[fidx][28:18], s.fen[fidx], s.fext[fidx], 3'h0};
                2'h1: rd = {14'h0, s.fid[fidx][17:0]};
                2'h2: rd = {26'h0, s.fmsel[fidx], s.fptr[fidx]};
                default: rd = 32'h0;
            endcase
        end else begin
            case (wb_adr_i)
                cmcrp_pkg::REG_CTRL1: rd = {21'h0, s.req, s.mode, 5'h0};
                cmcrp_pkg::REG_CFG2: rd = {17'h0, s.wake_fen, 14'h0};
                cmcrp_pkg::REG_FCTRL: rd = {16'h0, s.area_size, 8'h0, s.fifo_start};
                cmcrp_pkg::REG_INTF: rd = {25'h0, s.wake_flag, 3'h0, s.ovf, s.rx_buffer_flag, 1'b0};
                cmcrp_pkg::REG_INTE: rd = {30'h0, s.rx_ie, 1'b0};
                cmcrp_pkg::REG_BUFCON: rd = {8'h0, s.tx_abort_flag, s.tx_request_bit, s.dir};
                cmcrp_pkg::REG_RXFUL: rd = s.rxful;
                cmcrp_pkg::REG_VEC: rd = {19'h0, s.vec_filt, 3'h0, s.vec_buf};
                cmcrp_pkg::REG_BUFSEL: rd = {27'h0, s.bufsel};
                cmcrp_pkg::REG_BUFID: rd = {2'h0, s.bid[s.bufsel]};
                cmcrp_pkg::REG_BUFDLO: rd = s.bdata[s.bufsel][31:0];
                cmcrp_pkg::REG_BUFDHI: rd = s.bdata[s.bufsel][63:32];
                cmcrp_pkg::REG_STAT: rd = {20'h0, s.fresh_cnt, s.idle_cnt, 2'h0, s.seq};
                cmcrp_pkg::REG_MASK0: rd = {3'h0, s.mask[0]};
                cmcrp_pkg::REG_MASK0 + 12'h004: rd = {3'h0, s.mask[1]};
                cmcrp_pkg::REG_MASK0 + 12'h008: rd = {3'h0, s.mask[2]};
                default: rd = 32'h0;
            endcase
        end
    end

    // Acceptance: lowest-numbered enabled filter of the right format wins.
    always_comb begin
        hit_found = 1'b0;
        hit = 4'h0;
        cur_mask = 29'h0;
        for (int i = NFILT - 1; i >= 0; i--) begin
            cur_mask = (s.fmsel[i] == 2'h3) ? {29{1'b1}} : s.mask[s.fmsel[i]];
            if (s.fen[i] && s.fext[i] == pe_i.msg_ide &&
                match_f(s.fid[i], cur_mask, pe_i.msg_id, pe_i.msg_ide)) begin
                hit_found = 1'b1;
                hit = 4'(i);
            end
        end
    end

    // Target buffer choice; only pointers below 15 address a buffer directly.
    always_comb begin
        use_fifo = !hit_found || s.fptr[hit] == cmcrp_pkg::FIFO_PTR;
        free_idx = first_free_f(s.rxful, s.fifo_start, limit);
        tgt = use_fifo ? free_idx[4:0] : {1'b0, s.fptr[hit]};
        if (use_fifo) begin
            tgt_ok = !free_idx[5];
        end else begin
            tgt_ok = {1'b0, tgt} < limit && (tgt >= 5'h8 || !s.dir[tgt[2:0]]) && !s.rxful[tgt];
        end
        // Messages with errors are stored only in listen-all mode.
        store = rx_mode && (pe_i.msg_valid || (pe_i.msg_err && s.mode == cmcrp_pkg::MODE_LISTEN_ALL)) &&
                (hit_found || s.mode == cmcrp_pkg::MODE_LISTEN_ALL);
    end

    // ========================================================
    // Next-state logic: bus writes first, hardware events last so a set beats a clear.
    always_comb begin
        next_s = s;
        next_s.ack = req_take;
        next_s.sync = {s.sync[0], bus_receive_pin_i};
        next_s.bitdiv = bit_en ? 16'h0 : s.bitdiv + 16'h1;
        if (req_take && !wb_we_i) begin
            next_s.rdat = rd;
        end

        // Register writes; configuration is locked outside init mode.
        if (req_take && wb_we_i) begin
            if (in_filt && cfg_open) begin
                case (fsub)
                    2'h0: begin
                        next_s.fid[fidx][28:18] = wv[cmcrp_pkg::FSID_LSB +: 11];
                        next_s.fen[fidx] = wv[cmcrp_pkg::FEN_BIT];
                        next_s.fext[fidx] = wv[cmcrp_pkg::FEXT_BIT];
                    end
                    2'h1: next_s.fid[fidx][17:0] = wv[17:0];
                    2'h2: begin
                        next_s.fptr[fidx] = wv[cmcrp_pkg::FPTR_LSB +: 4];
                        next_s.fmsel[fidx] = wv[cmcrp_pkg::FMSEL_LSB +: 2];
                    end
                    default: next_s.fptr[fidx] = s.fptr[fidx];
                endcase
            end
            case (wb_adr_i)
                cmcrp_pkg::REG_CTRL1: next_s.req = wv[cmcrp_pkg::REQ_LSB +: 3];
                cmcrp_pkg::REG_CFG2: begin
                    if (cfg_open) begin
                        next_s.wake_fen = wv[cmcrp_pkg::WAKFEN_BIT];
                    end
                end
                cmcrp_pkg::REG_FCTRL: begin
                    if (cfg_open) begin
                        next_s.area_size = wv[cmcrp_pkg::AREA_LSB +: 3];
                        next_s.fifo_start = wv[cmcrp_pkg::FSTART_LSB +: 5];
                    end
                end
                cmcrp_pkg::REG_INTF: begin
                    next_s.rx_buffer_flag = s.rx_buffer_flag & ~w1c[cmcrp_pkg::RX_BUFFER_FLAG_BIT];
                    next_s.ovf = s.ovf & ~w1c[cmcrp_pkg::OVF_BIT];
                    next_s.wake_flag = s.wake_flag & ~w1c[cmcrp_pkg::WAKE_FLAG_BIT];
                end
                cmcrp_pkg::REG_INTE: begin
                    if (cfg_open) begin
                        next_s.rx_ie = wv[cmcrp_pkg::RX_BUFFER_IRQ_ENABLE_BIT];
                    end
                end
                cmcrp_pkg::REG_BUFCON: begin
                    next_s.dir = wv[cmcrp_pkg::DIR_LSB +: 8];
                    next_s.tx_request_bit = wv[cmcrp_pkg::TX_REQUEST_BIT_LSB +: 8];
                    // Raising a request clears that buffer's abort flag.
                    next_s.tx_abort_flag = s.tx_abort_flag & ~(wv[cmcrp_pkg::TX_REQUEST_BIT_LSB +: 8] & ~s.tx_request_bit);
                end
                cmcrp_pkg::REG_RXFUL: next_s.rxful = s.rxful & ~w1c;
                cmcrp_pkg::REG_BUFSEL: next_s.bufsel = wv[4:0];
                cmcrp_pkg::REG_MASK0: if (cfg_open) next_s.mask[0] = wv[28:0];
                cmcrp_pkg::REG_MASK0 + 12'h004: if (cfg_open) next_s.mask[1] = wv[28:0];
                cmcrp_pkg::REG_MASK0 + 12'h008: if (cfg_open) next_s.mask[2] = wv[28:0];
                default: next_s.bufsel = s.bufsel;
            endcase
        end

        // Bus idle detector: consecutive recessive bits, saturating at eleven.
        if (bit_en) begin
            if (s.sync[1]) begin
                next_s.idle_cnt = (s.idle_cnt == 4'(cmcrp_pkg::IDLE_BITS)) ? s.idle_cnt : s.idle_cnt + 4'h1;
                next_s.fresh_cnt = (s.fresh_cnt == 4'(cmcrp_pkg::IDLE_BITS)) ? s.fresh_cnt : s.fresh_cnt + 4'h1;
            end else begin
                next_s.idle_cnt = 4'h0;
            end
        end

        // Mode sequencer: a differing request waits for an idle bus and, for init, a quiet transmitter.
        case (s.seq)
            cmcrp_pkg::ST_STEADY: begin
                if (s.req != s.mode) begin
                    next_s.seq = cmcrp_pkg::ST_PEND;
                end
            end
            cmcrp_pkg::ST_PEND: begin
                if (s.req == s.mode) begin
                    next_s.seq = cmcrp_pkg::ST_STEADY;
                end else if (s.idle_cnt == 4'(cmcrp_pkg::IDLE_BITS) &&
                             !(s.req == cmcrp_pkg::MODE_INIT && pe_i.tx_busy)) begin
                    next_s.mode = s.req;
                    next_s.seq = cmcrp_pkg::ST_STEADY;
                    // Each entry opens a fresh eleven-bit wait before transmission.
                    next_s.fresh_cnt = 4'h0;
                end
            end
            default: next_s.seq = cmcrp_pkg::ST_STEADY;
        endcase

        // Disable requested during the startup wait aborts every pending transmission.
        if (tx_capable_f(s.mode) && s.req == cmcrp_pkg::MODE_DISABLE && s.fresh_cnt != 4'(cmcrp_pkg::IDLE_BITS) &&
            !pe_i.tx_busy) begin
            next_s.tx_abort_flag = next_s.tx_abort_flag | next_s.tx_request_bit;
            next_s.tx_request_bit = 8'h0;
        end

        // Wake detection in disable mode, optionally low-pass filtered.
        if (s.mode == cmcrp_pkg::MODE_DISABLE && !s.sync[1]) begin
            next_s.wake_cnt = (s.wake_cnt == 16'(WAKE_CYCLES)) ? s.wake_cnt : s.wake_cnt + 16'h1;
            if (!s.wake_fen || s.wake_cnt == 16'(WAKE_CYCLES - 1)) begin
                next_s.wake_flag = 1'b1;
            end
        end else begin
            next_s.wake_cnt = 16'h0;
        end

        // Storing a message at end of frame; flags set after any software clear.
        if (store) begin
            if (tgt_ok) begin
                next_s.bid[tgt] = {pe_i.msg_ide, pe_i.msg_id};
                next_s.bdata[tgt] = pe_i.msg_data;
                next_s.rxful[tgt] = 1'b1;
                next_s.rx_buffer_flag = 1'b1;
                next_s.vec_buf = tgt;
                next_s.vec_filt = hit_found ? {1'b0, hit} : cmcrp_pkg::VEC_NO_FILTER;
            end else if (use_fifo || s.rxful[tgt]) begin
                next_s.ovf = 1'b1;
            end
        end

        // Engine controls and pin ownership, decoded from the mode in force.
        next_s.po.rx_en = rx_mode;
        next_s.po.tx_en = tx_capable_f(s.mode);
        next_s.po.tx_allow = tx_capable_f(s.mode) && s.fresh_cnt == 4'(cmcrp_pkg::IDLE_BITS);
        next_s.po.ack_en = tx_capable_f(s.mode);
        next_s.po.errflag_en = tx_capable_f(s.mode);
        next_s.po.errcnt_clr = s.mode == cmcrp_pkg::MODE_INIT;
        next_s.po.errcnt_run = tx_capable_f(s.mode);
        next_s.po.ignore_err = s.mode == cmcrp_pkg::MODE_LISTEN_ALL;
        next_s.po.tx_req = s.tx_request_bit;
        next_s.po.rx_bit = (s.mode == cmcrp_pkg::MODE_LOOPBACK) ? pe_i.tx_bit : s.sync[1];
        next_s.tx_pin = (s.mode == cmcrp_pkg::MODE_NORMAL) ? pe_i.tx_bit : 1'b1;
        next_s.tx_oe = s.mode == cmcrp_pkg::MODE_NORMAL;
        next_s.rx_owned = s.mode != cmcrp_pkg::MODE_DISABLE && s.mode != cmcrp_pkg::MODE_LOOPBACK;
        next_s.irq = next_s.rx_buffer_flag && next_s.rx_ie;
    end

    // ========================================================
    // State register; reset lands in init mode with recessive outputs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.seq <= cmcrp_pkg::ST_STEADY;
            s.mode <= cmcrp_pkg::MODE_INIT;
            s.req <= cmcrp_pkg::MODE_INIT;
            s.sync <= 2'h3;
            s.tx_pin <= 1'b1;
            s.rx_owned <= 1'b1;
            s.po.rx_bit <= 1'b1;
            s.po.errcnt_clr <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;
    assign pe_o = s.po;
    assign bus_transmit_pin_o = s.tx_pin;
    assign bus_transmit_oe_o = s.tx_oe;
    assign bus_receive_owned_o = s.rx_owned;
    assign rx_irq_o = s.irq;

endmodule : cmcrp_top

//--- bench/cmcrp_properties.sv
`timescale 1ns/1ps
// ========================================
// Port checks on mode control and receive.
module cmcrp_properties #(
    parameter int BIT_CYCLES = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire cmcrp_pkg::cmcrp_pe_in_t pe_i,
    input wire cmcrp_pkg::cmcrp_pe_out_t pe_o,
    input wire logic bus_receive_pin_i,
    input wire logic bus_transmit_pin_o,
    input wire logic bus_transmit_oe_o,
    input wire logic bus_receive_owned_o,
    input wire logic rx_irq_o
);
    int rec;
    // Recessive run length on the raw pin; a dominant sample restarts it.
    always_ff @(posedge clk_i) begin
        rec <= (rst_i || !bus_receive_pin_i) ? 0 : rec + 1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_idle_gate: assert property ($rose(bus_transmit_oe_o) |-> rec >= 10 * BIT_CYCLES)
        else $error("bus taken before idle");
    a_pin_release: assert property (!bus_transmit_oe_o |-> bus_transmit_pin_o)
        else $error("released pin not recessive");
    a_pins_free: assert property (!bus_receive_owned_o |-> !bus_transmit_oe_o)
        else $error("tx driven with rx released");
    a_normal_run: assert property (bus_transmit_oe_o |-> pe_o.tx_en && pe_o.rx_en && pe_o.ack_en)
        else $error("normal mode not active");
    a_init_quiet: assert property (pe_o.errcnt_clr |-> !pe_o.tx_en && !pe_o.rx_en)
        else $error("traffic in init");
    a_passive_node: assert property (!pe_o.tx_en |-> !pe_o.ack_en && !pe_o.errflag_en)
        else $error("passive node signals");
    a_loop_route: assert property ((pe_o.rx_en && !bus_receive_owned_o)[*3]
        |-> pe_o.rx_bit == $past(pe_i.tx_bit)) else $error("loopback path broken");
    a_irq_cause: assert property ($rose(rx_irq_o) |-> $past(pe_i.msg_valid) || $past(pe_i.msg_valid, 2)
        || $past(pe_i.msg_err) || $past(pe_i.msg_err, 2) || wb_ack_o || $past(wb_ack_o))
        else $error("irq without cause");
    c_tx_on: cover property ($rose(bus_transmit_oe_o));
    c_irq: cover property ($rose(rx_irq_o));
    c_loop: cover property (pe_o.rx_en && !bus_receive_owned_o);
endmodule : cmcrp_properties

bind cmcrp_top cmcrp_properties #(.BIT_CYCLES(BIT_CYCLES)) i_cmcrp_properties (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pe_i(pe_i), .pe_o(pe_o),
    .bus_receive_pin_i(bus_receive_pin_i), .bus_transmit_pin_o(bus_transmit_pin_o),
    .bus_transmit_oe_o(bus_transmit_oe_o), .bus_receive_owned_o(bus_receive_owned_o), .rx_irq_o(rx_irq_o));

//--- bench/cmcrp_bus_node.sv
`timescale 1ns/1ps
// ========================================
// Another node on the shared bus.
module cmcrp_bus_node (
    input wire logic dom_i,
    input wire logic tx_pin_i,
    input wire logic tx_oe_i,
    output logic bus_o
);
    // Wired-AND line with pull-up: any dominant driver wins.
    assign bus_o = !dom_i && (!tx_oe_i || tx_pin_i);
endmodule : cmcrp_bus_node

//--- bench/tb_top.sv
`timescale 1ns/1ps
// ========================================
// Bench for mode control and receive path.
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic req = 1'b0, we = 1'b0, dom = 1'b0, ack, txp, oe, own, irq, rxp, ide;
    logic [11:0] adr = 12'h000;
    logic [31:0] wdat = 32'h00000000, rd_q, rdat;
    logic [15:0] lf = 16'h0007;
    logic [10:0] sid;
    cmcrp_pkg::cmcrp_pe_in_t pe = '{tx_bit: 1'b1, default: '0};
    int fails = 0, n_tests = 0;
    localparam logic [10:0] SID = 11'h5A3;
    // Clock.
    always #2.5 clk_i = ~clk_i;
    cmcrp_top #(.BIT_CYCLES(4), .WAKE_CYCLES(4)) i_cmcrp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
        .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rd_q),
        .wb_ack_o(ack), .pe_i(pe), .pe_o(), .bus_receive_pin_i(rxp), .bus_transmit_pin_o(txp),
        .bus_transmit_oe_o(oe), .bus_receive_owned_o(own), .rx_irq_o(irq));
    cmcrp_bus_node i_cmcrp_bus_node (.dom_i(dom), .tx_pin_i(txp), .tx_oe_i(oe), .bus_o(rxp));
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : nx
    // Only an enabled standard filter on SID aims at buffer 3.
    function automatic logic [31:0] exp_ful(input logic [10:0] s, input logic e);
        return (s == SID && !e) ? 32'h00000008 : 32'h00000000;
    endfunction : exp_ful
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Classic cycle: hold until ack is seen high at an edge.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            fails++;
            report_and_stop();
        end
        rdat = rd_q;
        req <= 1'b0;
        we <= 1'b0;
    endtask : bus
    task automatic wait_mode(input logic [2:0] m);
        for (int k = 0; k < 40 && rdat[7:5] !== m; k++) begin
            bus(1'b0, cmcrp_pkg::REG_CTRL1, 32'h0);
        end
        if (rdat[7:5] !== m) begin
            fails++;
            report_and_stop();
        end
        repeat (3) @(posedge clk_i);
    endtask : wait_mode
    // Main sequence.
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, cmcrp_pkg::REG_CTRL1, 32'h0);
        chk(rdat, 32'h00000480);
        bus(1'b1, cmcrp_pkg::REG_FCTRL, 32'h0000E005);
        bus(1'b0, cmcrp_pkg::REG_FCTRL, 32'h0);
        chk(rdat, 32'h0000E005);
        bus(1'b1, 12'h100, {16'h0000, SID, 5'h10});
        bus(1'b1, 12'h108, 32'h00000033);
        bus(1'b1, cmcrp_pkg::REG_INTE, 32'h00000002);
        bus(1'b1, cmcrp_pkg::REG_CTRL1, 32'h0);
        bus(1'b0, cmcrp_pkg::REG_CTRL1, 32'h0);
        chk(rdat, 32'h00000080);
        wait_mode(3'h0);
        chk({31'h0, oe}, 32'h1);
        bus(1'b1, cmcrp_pkg::REG_FCTRL, 32'h0);
        bus(1'b0, cmcrp_pkg::REG_FCTRL, 32'h0);
        chk(rdat, 32'h0000E005);
        $display("mode and lock test done");
        for (int i = 0; i < 8; i++) begin
            lf = nx(lf);
            sid = (i < 2 || lf[0]) ? SID : lf[11:1];
            ide = (i == 1) || (i > 1 && lf[12]);
            @(posedge clk_i);
            pe.msg_valid <= 1'b1;
            pe.msg_ide <= ide;
            pe.msg_id <= {sid, lf, 2'b01};
            pe.msg_data <= {lf, lf, ~lf, lf};
            @(posedge clk_i);
            pe.msg_valid <= 1'b0;
            bus(1'b0, cmcrp_pkg::REG_RXFUL, 32'h0);
            chk(rdat, exp_ful(sid, ide));
            chk({31'h0, irq}, {31'h0, rdat[3]});
            bus(1'b1, cmcrp_pkg::REG_INTF, 32'hFFFFFFFF);
            bus(1'b1, cmcrp_pkg::REG_RXFUL, 32'hFFFFFFFF);
            bus(1'b0, cmcrp_pkg::REG_INTF, 32'h0);
            chk({31'h0, rdat[1]}, 32'h0);
        end
        $display("receive test done");
        bus(1'b1, cmcrp_pkg::REG_CTRL1, 32'h00000200);
        wait_mode(3'h2);
        chk({30'h0, oe, own}, 32'h0);
        repeat (8) begin
            @(posedge clk_i);
            pe.tx_bit <= lf[0];
            lf = nx(lf);
        end
        @(posedge clk_i);
        pe.tx_bit <= 1'b1;
        $display("loopback test done");
        bus(1'b1, cmcrp_pkg::REG_CTRL1, 32'h00000100);
        wait_mode(3'h1);
        chk({31'h0, own}, 32'h0);
        dom <= 1'b1;
        repeat (6) @(posedge clk_i);
        dom <= 1'b0;
        bus(1'b0, cmcrp_pkg::REG_INTF, 32'h0);
        chk({31'h0, rdat[6]}, 32'h1);
        pe.tx_busy <= 1'b1;
        bus(1'b1, cmcrp_pkg::REG_CTRL1, 32'h00000400);
        repeat (60) @(posedge clk_i);
        bus(1'b0, cmcrp_pkg::REG_CTRL1, 32'h0);
        chk(rdat, 32'h00000420);
        pe.tx_busy <= 1'b0;
        wait_mode(3'h4);
        $display("disable test done");
        report_and_stop();
    end
endmodule : tb_top
